// file: hw/lmem_cycle.sv
// local memory cycle signalling: status codes, address mux, bus sizing
// assumes straps come from external logic off this clock; requests same clock
`include "lmem_defines.svh"
`default_nettype none
module lmem_cycle
  import lmem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req_valid,
  input wire req_t i_req,
  input wire logic i_big_endian,
  input wire straps_t i_straps,
  output logic o_req_ready,
  output logic [5:0] o_status,
  output logic [31:0] o_addr,
  output logic [63:0] o_data,
  output logic [7:0] o_col_strobe_n,
  output logic o_row_latch_strobe,
  output logic o_row_phase,
  output logic o_col_phase,
  output logic [2:0] o_cycle_timing,
  output logic o_sdram_timing,
  output logic o_sdram_interleaved,
  output logic o_cas_latency3,
  output logic o_done
);

  // ----------------------------------------
  // strap synchronisers
  // ----------------------------------------
  straps_t strap_meta_reg; // first stage, read only by second
  straps_t strap_sync_reg; // second stage
  // two flops before use
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
    end else begin
      strap_meta_reg <= i_straps;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ----------------------------------------
  // state and captured request
  // ----------------------------------------
  state_t state_reg; // cycle phase
  state_t state_next;
  req_t req_reg; // request in progress
  straps_t cap_reg; // straps latched at row time
  logic [3:0] left_reg; // bytes still to move
  logic [31:0] cur_addr_reg; // address of current column
  logic [3:0] width_bytes; // bytes per column for captured width
  logic [3:0] step; // bytes moved this column
  logic [4:0] shift; // column shift amount
  logic [3:0] total_bytes; // bytes of the whole access, zero meaning eight
  straps_t col_straps; // straps for the column address
  req_t src_req; // request whose row code is shown
  logic [31:0] col_base; // logical address of the column being driven
  logic [31:0] col_shifted; // column address moved up onto the pins

  // accept only when idle
  assign o_req_ready = (state_reg == S_IDLE);
  // row code must describe the access from its first row cycle
  assign src_req = (state_reg == S_IDLE) ? i_req : req_reg;
  // a zero count asks for a whole eight-byte word
  assign total_bytes = (req_reg.nbytes == 4'h0) ? `BYTES_64 : req_reg.nbytes;
  // first column address needs the straps being captured now
  assign col_straps = (state_reg == S_ROW2) ? strap_sync_reg : cap_reg;

  // next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (i_req_valid) begin
          state_next = S_ROW1;
        end
      end
      S_ROW1: begin
        state_next = S_ROW2;
      end
      S_ROW2: begin
        state_next = S_COL;
      end
      S_COL: begin
        if (left_reg <= step) begin
          state_next = S_DONE;
        end
      end
      S_DONE: begin
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // request capture
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      req_reg <= '0;
    end else if (state_reg == S_IDLE && i_req_valid) begin
      req_reg <= i_req;
    end
  end

  // strap capture
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cap_reg <= '0;
    end else if (state_reg == S_ROW2) begin
      cap_reg <= strap_sync_reg;
    end
  end

  // bytes per column
  always_comb begin
    width_bytes = `BYTES_64;
    case (cap_reg.bus_width_select)
      `BW_8: width_bytes = `BYTES_8;
      `BW_16: width_bytes = `BYTES_16;
      `BW_32: width_bytes = `BYTES_32;
      default: width_bytes = `BYTES_64;
    endcase
  end
  assign step = (left_reg < width_bytes) ? left_reg : width_bytes;

  // byte count and column address
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      left_reg <= '0;
      cur_addr_reg <= '0;
    end else if (state_reg == S_ROW1) begin
      left_reg <= total_bytes;
      cur_addr_reg <= req_reg.addr;
    end else if (state_reg == S_COL) begin
      left_reg <= left_reg - step;
      cur_addr_reg <= cur_addr_reg + {28'h000_0000, step};
    end
  end

  // ----------------------------------------
  // status codes
  // ----------------------------------------
  logic [5:0] row_code;
  logic [5:0] col_code;

  // row-time cycle type
  always_comb begin
    row_code = `ST_IDLE;
    case (src_req.kind)
      K_READ: row_code = (src_req.unit == U_OTHER) ? `ST_ROW_PT_READ : `ST_ROW_READ;
      K_WRITE: row_code = (src_req.unit == U_OTHER) ? `ST_ROW_PT_WRITE : `ST_ROW_WRITE;
      K_REFRESH: row_code = `ST_ROW_REFRESH;
      K_DEACT: row_code = `ST_ROW_DEACT;
      K_PDT_READ: row_code = `ST_ROW_PDT_READ;
      K_PDT_WRITE: row_code = `ST_ROW_PDT_WRITE;
      // frame transfers, low bits pick type
      K_FRAME: row_code = (src_req.frame_sel ? `ST_ROW_FRAME1 : `ST_ROW_FRAME0)
                          | {4'h0, src_req.sub};
      K_DRAIN: row_code = `ST_ROW_WRITE;
      default: row_code = `ST_IDLE;
    endcase
  end

  // column-time requester code
  always_comb begin
    col_code = `ST_IDLE;
    if (req_reg.kind == K_DRAIN || req_reg.kind == K_DEACT) begin
      col_code = `ST_COL_DRAIN;
    end else if (req_reg.kind == K_REFRESH) begin
      col_code = `ST_COL_REFRESH;
    end else if (req_reg.kind == K_FRAME) begin
      col_code = `ST_COL_FRAME0 | {5'h00, req_reg.frame_sel};
    end else if (req_reg.unit == U_PPU) begin
      col_code = `ST_COL_PPU_BASE | {2'h0, req_reg.ppu_num, req_reg.sub};
    end else if (req_reg.unit == U_MPU) begin
      case (req_reg.mpu_cls)
        3'h0: col_code = `ST_COL_MPU_BASE;
        3'h1: col_code = `ST_COL_MPU_BASE | 6'h01;
        3'h2: col_code = `ST_COL_MPU_URGENT | {5'h00, req_reg.hi_mode};
        // pairs, higher code in high mode
        3'h3: col_code = `ST_COL_MPU_ICACHE | {5'h00, req_reg.hi_mode};
        3'h4: col_code = `ST_COL_MPU_DEA | {5'h00, req_reg.hi_mode};
        3'h5: col_code = `ST_COL_MPU_DCACHE | {5'h00, req_reg.hi_mode};
        default: col_code = `ST_IDLE;
      endcase
    end
  end

  // status output register
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status <= `ST_IDLE;
    end else begin
      case (state_next)
        S_ROW1, S_ROW2: o_status <= row_code;
        S_COL: o_status <= col_code;
        default: o_status <= `ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // address multiplexing
  // ----------------------------------------
  always_comb begin
    shift = `SH_NONE;
    case (col_straps.row_col_shift_select)
      3'h0: shift = `SH_NONE;
      3'h1: shift = `SH_8;
      3'h2: shift = `SH_9;
      3'h3: shift = `SH_11;
      3'h4: shift = `SH_10;
      3'h5: shift = `SH_12;
      3'h6: shift = `SH_13;
      default: shift = `SH_14;
    endcase
  end

  // next column address while columns repeat
  assign col_base = (state_reg == S_COL) ? cur_addr_reg + {28'h000_0000, step}
                                         : cur_addr_reg;
  // logical address moves up onto the pins
  assign col_shifted = col_base << shift;

  // address output
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_addr <= '0;
    end else if (state_next == S_ROW1) begin
      // whole byte address from first row cycle
      o_addr <= i_req.addr;
    end else if (state_next == S_COL) begin
      o_addr <= {col_shifted[31:3], col_base[2:0]};
    end
  end

  // ----------------------------------------
  // byte lanes and data alignment
  // ----------------------------------------
  logic [7:0] lane_mask;
  logic [5:0] lane_base; // first active lane index times eight
  logic [2:0] first_lane;

  // lane selection by width and endianness
  always_comb begin
    lane_mask = 8'hff;
    first_lane = 3'h0;
    case (cap_reg.bus_width_select)
      `BW_8: begin
        lane_mask = i_big_endian ? 8'h80 : 8'h01;
        first_lane = i_big_endian ? 3'h7 : 3'h0;
      end
      `BW_16: begin
        lane_mask = i_big_endian ? 8'hc0 : 8'h03;
        first_lane = i_big_endian ? 3'h6 : 3'h0;
      end
      `BW_32: begin
        lane_mask = i_big_endian ? 8'hf0 : 8'h0f;
        first_lane = i_big_endian ? 3'h4 : 3'h0;
      end
      default: begin
        lane_mask = 8'hff;
        first_lane = 3'h0;
      end
    endcase
  end
  assign lane_base = {first_lane, 3'h0};

  logic [3:0] done_bytes; // bytes already moved
  logic [63:0] shifted_data;
  logic [7:0] valid_bytes;
  assign done_bytes = total_bytes - left_reg;
  assign shifted_data = (req_reg.wdata >> {done_bytes, 3'h0}) << lane_base;
  assign valid_bytes = (8'hff >> (4'h8 - step)) << first_lane;

  // data and strobes
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_data <= '0;
      o_col_strobe_n <= 8'hff;
    end else if (state_reg == S_COL) begin
      // align and strobe only valid bytes
      o_data <= shifted_data;
      o_col_strobe_n <= ~(valid_bytes & lane_mask);
    end else begin
      o_col_strobe_n <= 8'hff;
    end
  end

  // ----------------------------------------
  // phase flags and timing decode
  // ----------------------------------------
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_row_latch_strobe <= 1'b0;
      o_row_phase <= 1'b0;
      o_col_phase <= 1'b0;
      o_done <= 1'b0;
    end else begin
      // latch strobe in second row state
      o_row_latch_strobe <= (state_next == S_ROW2);
      o_row_phase <= (state_next == S_ROW1) || (state_next == S_ROW2);
      o_col_phase <= (state_next == S_COL);
      o_done <= (state_next == S_DONE);
    end
  end

  // timing decode from captured code
  // sdram modes and latency
  assign o_cycle_timing = cap_reg.cycle_timing_code;
  assign o_sdram_timing = ~cap_reg.cycle_timing_code[2];
  assign o_sdram_interleaved = ~cap_reg.cycle_timing_code[2] & cap_reg.cycle_timing_code[1];
  assign o_cas_latency3 = ~cap_reg.cycle_timing_code[2] & cap_reg.cycle_timing_code[0];

endmodule
`default_nettype wire

// file: hw/lmem_defines.svh
// constants for the local memory cycle signalling block
// assumes inclusion by bare name from hw/ sources
`ifndef LMEM_DEFINES_SVH
`define LMEM_DEFINES_SVH
// row-time cycle type codes
`define ST_ROW_READ 6'h00
`define ST_ROW_WRITE 6'h01
`define ST_ROW_REFRESH 6'h02
`define ST_ROW_DEACT 6'h03
`define ST_ROW_PDT_READ 6'h04
`define ST_ROW_PDT_WRITE 6'h05
`define ST_ROW_FRAME0 6'h10
`define ST_ROW_FRAME1 6'h14
`define ST_ROW_PT_READ 6'h1c
`define ST_ROW_PT_WRITE 6'h1d
`define ST_IDLE 6'h1f
// column-time requester codes
`define ST_COL_PPU_BASE 6'h00
`define ST_COL_MPU_BASE 6'h10
`define ST_COL_MPU_URGENT 6'h12
`define ST_COL_MPU_ICACHE 6'h16
`define ST_COL_MPU_DEA 6'h18
`define ST_COL_MPU_DCACHE 6'h1a
`define ST_COL_FRAME0 6'h1c
`define ST_COL_REFRESH 6'h1e
`define ST_COL_DRAIN 6'h3f
// column address shift amounts
`define SH_NONE 5'h00
`define SH_8 5'h08
`define SH_9 5'h09
`define SH_10 5'h0a
`define SH_11 5'h0b
`define SH_12 5'h0c
`define SH_13 5'h0d
`define SH_14 5'h0e
// bus width selects
`define BW_8 2'h0
`define BW_16 2'h1
`define BW_32 2'h2
`define BW_64 2'h3
`define BYTES_8 4'h1
`define BYTES_16 4'h2
`define BYTES_32 4'h4
`define BYTES_64 4'h8
`endif

// file: hw/lmem_pkg.sv
// types for the local memory cycle signalling block
// assumes lmem_defines.svh is available for the constants
`default_nettype none
package lmem_pkg;
  // access kinds offered by the requester
  typedef enum logic [3:0] {
    K_READ = 4'h0,
    K_WRITE = 4'h1,
    K_REFRESH = 4'h2,
    K_DEACT = 4'h3,
    K_PDT_READ = 4'h4,
    K_PDT_WRITE = 4'h5,
    K_FRAME = 4'h6,
    K_DRAIN = 4'h7
  } kind_t;
  // requesting unit classes
  typedef enum logic [1:0] {
    U_PPU = 2'h0,
    U_MPU = 2'h1,
    U_OTHER = 2'h2
  } unit_t;
  // one access request from the transfer logic
  typedef struct packed {
    kind_t kind;
    unit_t unit;
    logic [1:0] ppu_num;
    logic [1:0] sub;
    logic [2:0] mpu_cls;
    logic hi_mode;
    logic frame_sel;
    logic [31:0] addr;
    logic [3:0] nbytes;
    logic [63:0] wdata;
  } req_t;
  // row-time strap inputs from the bank decode logic
  typedef struct packed {
    logic [2:0] row_col_shift_select;
    logic [1:0] bus_width_select;
    logic [2:0] cycle_timing_code;
    logic [3:0] page_size_select;
    logic user_timing_input;
  } straps_t;
  // cycle phase states
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ROW1 = 5'b00010,
    S_ROW2 = 5'b00100,
    S_COL = 5'b01000,
    S_DONE = 5'b10000
  } state_t;
endpackage
`default_nettype wire

// file: verif/lmem_cycle_assertions.sv
// checker: port relations of lmem_cycle
// assumes one clock and an async active-low reset
`default_nettype none
module lmem_cycle_checker
  import lmem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_req_valid,
  input wire req_t i_req,
  input wire logic i_big_endian,
  input wire straps_t i_straps,
  input wire logic o_req_ready,
  input wire logic [5:0] o_status,
  input wire logic [31:0] o_addr,
  input wire logic [63:0] o_data,
  input wire logic [7:0] o_col_strobe_n,
  input wire logic o_row_latch_strobe,
  input wire logic o_row_phase,
  input wire logic o_col_phase,
  input wire logic [2:0] o_cycle_timing,
  input wire logic o_sdram_timing,
  input wire logic o_sdram_interleaved,
  input wire logic o_cas_latency3,
  input wire logic o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // helper logic
  // ----------------
  wire logic take = i_req_valid && o_req_ready; // request accepted
  logic [31:0] addr_reg; // address of the accepted request
  // keep the accepted address
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_reg <= 32'h0000_0000;
    end else if (take) begin
      addr_reg <= i_req.addr;
    end
  end
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  // ----------------
  // properties
  // ----------------
  AST_ROW_SEQ:
    assert property (take |=> o_row_phase && o_status != 6'h1f ##1 o_row_latch_strobe)
    else $error("row sequence wrong");
  AST_ROW_ADDR:
    assert property (o_row_phase |-> o_addr == addr_reg)
    else $error("row address wrong");
  AST_ROW_STATUS:
    assert property (o_row_latch_strobe |-> $stable(o_status))
    else $error("row code changed within row time");
  AST_NO_RESERVED:
    assert property (o_status[5] |-> o_status == 6'h3f)
    else $error("reserved status code");
  AST_DONE_BOUND:
    assert property (take |-> ##[4:24] o_done)
    else $error("access never completed");
  AST_DONE_PULSE:
    assert property (o_done |=> !o_done && o_req_ready)
    else $error("done not a single pulse");
  AST_COL_EXCL:
    assert property (o_col_phase |-> !o_row_phase && !o_req_ready)
    else $error("column phase overlaps");
  AST_TIMING_HOLD:
    assert property (o_col_phase && $past(o_col_phase) |-> $stable(o_cycle_timing))
    else $error("timing changed in column");
  AST_SDRAM_DEC:
    assert property (o_col_phase && !o_cycle_timing[2] |-> o_sdram_timing
      && o_sdram_interleaved == o_cycle_timing[1] && o_cas_latency3 == o_cycle_timing[0])
    else $error("sdram decode wrong");
  AST_IDLE_CODE:
    assert property (o_req_ready && $past(o_req_ready) |-> o_status == 6'h1f
      && o_col_strobe_n == 8'hff)
    else $error("idle outputs wrong");
  AST_STROBE_COL:
    assert property (o_col_strobe_n != 8'hff |-> $past(o_col_phase))
    else $error("strobe outside column");
endmodule
bind lmem_cycle lmem_cycle_checker chk (
  .i_mclk, .i_nrst, .i_req_valid, .i_req, .i_big_endian, .i_straps,
  .o_req_ready, .o_status, .o_addr, .o_data, .o_col_strobe_n,
  .o_row_latch_strobe, .o_row_phase, .o_col_phase, .o_cycle_timing,
  .o_sdram_timing, .o_sdram_interleaved, .o_cas_latency3, .o_done
);
`default_nettype wire

// file: verif/lmem_far_side.sv
// far-side model: memory and bank decode watching the pins
// assumes the same clock as lmem_cycle; counts, lane flag and data cleared by each row strobe
`default_nettype none
module lmem_far_side
  import lmem_pkg::*;
(
  input wire logic i_mclk,
  input wire straps_t i_straps,
  input wire logic i_big_endian,
  input wire logic [5:0] i_status,
  input wire logic [31:0] i_addr,
  input wire logic [63:0] i_data,
  input wire logic [7:0] i_col_strobe_n,
  input wire logic i_row_latch_strobe,
  input wire logic i_col_phase,
  output logic [5:0] o_row_code,
  output logic [5:0] o_col_code,
  output logic [31:0] o_col_addr,
  output logic [7:0] o_ncols,
  output logic [7:0] o_nbytes,
  output logic o_lane_bad,
  output logic [63:0] o_le_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_col; // column phase seen last cycle
  logic [7:0] win; // lanes legal for width and order
  int w; // bus width in bytes
  // legal lane window
  always_comb begin
    w = 1 << i_straps.bus_width_select;
    win = i_big_endian ? ~(8'hff >> w) : ~(8'hff << w);
  end
  // watch row and column cycles
  always @(posedge i_mclk) begin
    if (i_row_latch_strobe) begin
      o_row_code = i_status;
      o_ncols = 8'h00;
      o_nbytes = 8'h00;
      o_lane_bad = 1'b0;
      o_le_data = 64'h0;
    end
    if (i_col_phase && !in_col) begin
      o_col_code = i_status;
      o_col_addr = i_addr;
    end
    in_col = i_col_phase;
    if (i_col_strobe_n != 8'hff) begin
      o_ncols++;
      if (|(~i_col_strobe_n & ~win)) o_lane_bad = 1'b1;
      for (int k = 0; k < 8; k++) begin
        if (!i_col_strobe_n[k]) begin
          o_le_data[o_nbytes*8 +: 8] = i_data[k*8 +: 8];
          o_nbytes++;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// bench for lmem_cycle: code table, sizing, shift, timing, reset
// assumes the checker binds itself; far side is lmem_far_side
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lmem_pkg::*;
  typedef struct packed {
    kind_t k;
    unit_t u;
    logic [1:0] n;
    logic [1:0] s;
    logic [2:0] c;
    logic h;
    logic f;
    logic [5:0] r;
    logic [5:0] q;
  } row_t;
  logic i_mclk, i_nrst, i_req_valid, i_big_endian;
  req_t i_req;
  straps_t i_straps;
  logic o_req_ready, o_row_latch_strobe, o_row_phase, o_col_phase, o_done;
  logic o_sdram_timing, o_sdram_interleaved, o_cas_latency3;
  logic [5:0] o_status, m_row, m_col;
  logic [31:0] o_addr, m_caddr;
  logic [63:0] o_data, m_data;
  logic [7:0] o_col_strobe_n, m_ncols, m_nbytes;
  logic [2:0] o_cycle_timing;
  logic m_bad;
  int fail_count = 0;
  int comparisons = 0;
  int sht [8] = '{0, 8, 9, 11, 10, 12, 13, 14};
  localparam straps_t s64 = '{3'h0, 2'h3, 3'h4, 4'h0, 1'b0};
  row_t rows [20] = '{
    '{K_READ, U_PPU, 2, 1, 0, 0, 0, 6'h00, 6'h09}, '{K_WRITE, U_PPU, 3, 3, 0, 0, 0, 6'h01, 6'h0f},
    '{K_READ, U_MPU, 0, 0, 0, 0, 0, 6'h00, 6'h10}, '{K_WRITE, U_MPU, 0, 0, 1, 0, 0, 6'h01, 6'h11},
    '{K_READ, U_MPU, 0, 0, 2, 0, 0, 6'h00, 6'h12}, '{K_READ, U_MPU, 0, 0, 2, 1, 0, 6'h00, 6'h13},
    '{K_READ, U_MPU, 0, 0, 3, 0, 0, 6'h00, 6'h16}, '{K_READ, U_MPU, 0, 0, 3, 1, 0, 6'h00, 6'h17},
    '{K_READ, U_MPU, 0, 0, 4, 0, 0, 6'h00, 6'h18}, '{K_READ, U_MPU, 0, 0, 4, 1, 0, 6'h00, 6'h19},
    '{K_READ, U_MPU, 0, 0, 5, 0, 0, 6'h00, 6'h1a}, '{K_READ, U_MPU, 0, 0, 5, 1, 0, 6'h00, 6'h1b},
    '{K_PDT_READ, U_MPU, 0, 0, 0, 0, 0, 6'h04, 6'h10},
    '{K_PDT_WRITE, U_MPU, 0, 0, 0, 0, 0, 6'h05, 6'h10},
    '{K_FRAME, U_OTHER, 0, 2, 0, 0, 0, 6'h12, 6'h1c},
    '{K_FRAME, U_OTHER, 0, 3, 0, 0, 1, 6'h17, 6'h1d},
    '{K_REFRESH, U_OTHER, 0, 0, 0, 0, 0, 6'h02, 6'h1e},
    '{K_DEACT, U_OTHER, 0, 0, 0, 0, 0, 6'h03, 6'h3f},
    '{K_DRAIN, U_OTHER, 0, 0, 0, 0, 0, 6'h01, 6'h3f},
    '{K_WRITE, U_OTHER, 0, 0, 0, 0, 0, 6'h1d, 6'h1f}};
  lmem_cycle dut (
    .i_mclk, .i_nrst, .i_req_valid, .i_req, .i_big_endian, .i_straps,
    .o_req_ready, .o_status, .o_addr, .o_data, .o_col_strobe_n,
    .o_row_latch_strobe, .o_row_phase, .o_col_phase, .o_cycle_timing,
    .o_sdram_timing, .o_sdram_interleaved, .o_cas_latency3, .o_done);
  lmem_far_side mem (
    .i_mclk, .i_straps, .i_big_endian, .i_status(o_status), .i_addr(o_addr),
    .i_data(o_data), .i_col_strobe_n(o_col_strobe_n), .i_row_latch_strobe(o_row_latch_strobe),
    .i_col_phase(o_col_phase), .o_row_code(m_row), .o_col_code(m_col), .o_col_addr(m_caddr),
    .o_ncols(m_ncols), .o_nbytes(m_nbytes), .o_lane_bad(m_bad), .o_le_data(m_data));
  // compare and count
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic req_t mk(kind_t k, unit_t u, logic [1:0] n, logic [1:0] s,
                              logic [2:0] c, logic h, logic f, logic [3:0] nb);
    mk = '{k, u, n, s, c, h, f, 32'h9abc_def0, nb, 64'h8877_6655_4433_2211};
  endfunction
  // one whole access; straps settle through the sync first
  task automatic go(req_t r, straps_t s, logic be);
    int n;
    i_straps = s;
    i_big_endian = be;
    repeat (3) @(negedge i_mclk);
    i_req = r;
    i_req_valid = 1'b1;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 60) begin
      @(negedge i_mclk);
      n++;
    end
    if (n == 60) begin
      check("timeout", 1, 0);
      complete_run();
    end
    repeat (2) @(negedge i_mclk);
  endtask
  // clock
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  // main sequence
  initial begin
    logic [31:0] msk, ex;
    req_t r;
    i_nrst = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    i_big_endian = 1'b0;
    i_straps = s64;
    repeat (20) @(negedge i_mclk);
    i_nrst = 1'b1;
    @(negedge i_mclk);
    check("reset", {o_status, o_col_strobe_n, o_req_ready, o_done}, 16'h7ffe);
    foreach (rows[i]) begin
      go(mk(rows[i].k, rows[i].u, rows[i].n, rows[i].s, rows[i].c, rows[i].h, rows[i].f,
            4'h8), s64, 1'b0);
      check("row code", m_row, rows[i].r);
      check("col code", m_col, rows[i].q);
    end
    // sizing over widths and byte orders with 7 bytes, then 8 bytes at 16-bit little-endian only
    for (int w = 0; w < 4; w++) begin
      for (int b = 0; b < 2; b++) begin
        go(mk(K_WRITE, U_MPU, 0, 0, 0, 0, 0, 4'h7), '{3'h0, 2'(w), 3'h4, 4'h0, 1'b0}, 1'(b));
        check("columns", m_ncols, (7 + (1 << w) - 1) >> w);
        check("bytes", m_nbytes, 7);
        check("lanes", m_bad, 0);
        check("data", m_data, 64'h0077_6655_4433_2211);
      end
    end
    go(mk(K_WRITE, U_PPU, 0, 0, 0, 0, 0, 4'h0), '{3'h0, 2'h1, 3'h4, 4'h0, 1'b0}, 1'b0);
    check("full columns", m_ncols, 4);
    check("full data", m_data, 64'h8877_6655_4433_2211);
    // every shift select and timing code
    for (int a = 0; a < 8; a++) begin
      r = mk(K_READ, U_PPU, 0, 0, 0, 0, 0, 4'h8);
      r.addr = 32'hfedc_ba97;
      go(r, '{3'(a), 2'h3, 3'(a), 4'h0, 1'b0}, 1'b0);
      msk = (32'hffff_ffff << sht[a]) | 32'h7;
      ex = (r.addr << sht[a]) & msk | r.addr & 32'h7;
      check("col addr", m_caddr & msk, ex);
      check("timing", o_cycle_timing, a);
      check("sdram", o_sdram_timing, a < 4);
      if (a < 4) check("sdram kind", {o_sdram_interleaved, o_cas_latency3}, a);
    end
    // reset in the middle of an access
    i_req = mk(K_WRITE, U_MPU, 0, 0, 0, 0, 0, 4'h8);
    i_req_valid = 1'b1;
    @(negedge i_mclk);
    i_req_valid = 1'b0;
    repeat (2) @(negedge i_mclk);
    i_nrst = 1'b0;
    @(negedge i_mclk);
    check("mid reset", {o_status, o_col_strobe_n, o_req_ready, o_done}, 16'h7ffe);
    i_nrst = 1'b1;
    go(mk(K_READ, U_PPU, 1, 0, 0, 0, 0, 4'h8), s64, 1'b0);
    check("after reset", m_col, 6'h04);
    complete_run();
  end
endmodule
`default_nettype wire
